// ===== design/sspm_ctrl.sv
// Switching clock generator with standalone, master and slave sync modes
`timescale 1ns/10ps
`default_nettype none
module sspm_ctrl (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [15:0] phase_mode_command_i,
    input wire logic phase_mode_wr_i,
    input wire logic [15:0] freq_cmd_period_i,
    input wire logic freq_cmd_wr_i,
    input wire logic [15:0] freq_set_resistor_period_i,
    input wire logic freq_set_resistor_valid_i,
    input wire logic freq_set_sync_pin_i,
    output logic freq_set_sync_pin_o,
    output logic freq_set_sync_pin_oe_o,
    output logic sense_req_o,
    output logic sw_node_o,
    output logic [1:0] mode_o,
    output logic sync_locked_o,
    output logic [15:0] period_o
);
    sspm_pkg::sspm_mode_t mode_r;
    logic powered_r;
    logic [15:0] def_per_r;
    logic [15:0] cnt_r;
    logic sw_r;
    logic ext_rise;
    logic ext_present;
    logic [15:0] ext_per;
    logic slave;
    logic [15:0] act_per;
    logic wrap;

    sspm_sync_detect u_det (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .pin_i(freq_set_sync_pin_i),
        .rise_o(ext_rise),
        .present_o(ext_present),
        .period_o(ext_per)
    );

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            mode_r <= sspm_pkg::SSPM_STANDALONE;
        end else if (phase_mode_wr_i) begin
            case (phase_mode_command_i)
                sspm_pkg::PH_STANDALONE: mode_r <= sspm_pkg::SSPM_STANDALONE;
                sspm_pkg::PH_MASTER: mode_r <= sspm_pkg::SSPM_MASTER;
                sspm_pkg::PH_SLAVE_IN: mode_r <= sspm_pkg::SSPM_SLAVE_IN;
                sspm_pkg::PH_SLAVE_180: mode_r <= sspm_pkg::SSPM_SLAVE_180;
                // Unknown codes keep the current mode
                default: mode_r <= mode_r;
            endcase
        end
    end

    // Power up ends when the single resistor measurement lands
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            powered_r <= 1'b0;
            def_per_r <= sspm_pkg::PER_RESET;
        end else if (!powered_r && freq_set_resistor_valid_i) begin
            powered_r <= 1'b1;
            def_per_r <= (freq_set_resistor_period_i < sspm_pkg::PER_MIN) ? sspm_pkg::PER_MIN
                         : freq_set_resistor_period_i;
        end else if (powered_r && freq_cmd_wr_i) begin
            // Command wins over the sensed default
            def_per_r <= (freq_cmd_period_i < sspm_pkg::PER_MIN) ? sspm_pkg::PER_MIN
                         : freq_cmd_period_i;
        end
    end

    assign sense_req_o = ~powered_r;
    assign slave = (mode_r == sspm_pkg::SSPM_SLAVE_IN) || (mode_r == sspm_pkg::SSPM_SLAVE_180);
    assign act_per = (slave && ext_present && ext_per >= sspm_pkg::PER_MIN) ? ext_per : def_per_r;
    assign wrap = (cnt_r >= act_per - 16'h0001);

    // Counter restarts on the external edge so the node tracks its phase
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !powered_r) begin
            cnt_r <= '0;
        end else if (slave && ext_present && ext_rise) begin
            cnt_r <= 16'h0001;
        end else if (wrap) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 16'h0001;
        end
    end

    // High for the first half of the period; 180 mode with an external clock present takes the second half, less its last cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !powered_r) begin
            sw_r <= 1'b0;
        end else if (mode_r == sspm_pkg::SSPM_SLAVE_180 && ext_present) begin
            sw_r <= (cnt_r >= (act_per >> 1)) && !(ext_rise) && !wrap;
        end else begin
            sw_r <= (cnt_r < (act_per >> 1)) || (ext_rise && slave && ext_present);
        end
    end

    assign sw_node_o = sw_r;
    // Pin carries the node itself in master mode, so phase cannot drift
    assign freq_set_sync_pin_o = sw_r;
    assign freq_set_sync_pin_oe_o = powered_r && (mode_r == sspm_pkg::SSPM_MASTER);
    assign mode_o = mode_r;
    assign sync_locked_o = slave && ext_present;
    assign period_o = act_per;

    mode_cmd_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        phase_mode_wr_i && phase_mode_command_i == sspm_pkg::PH_MASTER |=> mode_o == 2'b01)
        else $error("phase-mode write did not select master");
    pin_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode_o != 2'b01 |-> !freq_set_sync_pin_oe_o)
        else $error("sync pin driven outside master mode");
    master_drive_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $past(powered_r) && powered_r && mode_o == 2'b01 |-> freq_set_sync_pin_oe_o)
        else $error("master does not drive sync pin");
    master_phase_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        freq_set_sync_pin_oe_o |-> freq_set_sync_pin_o == sw_node_o)
        else $error("sync output out of phase with node");
    slave_in_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode_o == 2'b10 && ext_present && ext_rise && powered_r |=> sw_node_o)
        else $error("in-phase slave not high after external edge");
    slave_180_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        mode_o == 2'b11 && ext_present && ext_rise && powered_r |=> !sw_node_o)
        else $error("180 slave not low after external edge");
    ext_freq_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        slave && ext_present && ext_per >= sspm_pkg::PER_MIN |-> period_o == ext_per)
        else $error("external period not taken");
    sense_once_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        powered_r |=> powered_r && !sense_req_o)
        else $error("resistor sensed again");
    freq_cmd_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        powered_r && freq_cmd_wr_i && freq_cmd_period_i >= sspm_pkg::PER_MIN
        |=> def_per_r == $past(freq_cmd_period_i))
        else $error("frequency command ignored");
    no_clock_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !ext_present |-> period_o == def_per_r)
        else $error("default period not used without clock");
    unknown_code_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        phase_mode_wr_i && phase_mode_command_i != sspm_pkg::PH_STANDALONE
        && phase_mode_command_i != sspm_pkg::PH_MASTER && phase_mode_command_i != sspm_pkg::PH_SLAVE_IN
        && phase_mode_command_i != sspm_pkg::PH_SLAVE_180 |=> mode_o == $past(mode_o))
        else $error("unknown phase-mode code changed the mode");
    powerup_release_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !powered_r |-> !freq_set_sync_pin_oe_o)
        else $error("sync pin driven before power up");
    powerup_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !powered_r |=> !sw_node_o)
        else $error("node switching before power up");
    master_start_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        powered_r && mode_r == sspm_pkg::SSPM_MASTER && cnt_r == 16'h0000 |=> freq_set_sync_pin_o)
        else $error("master pulse not high at period start");
    // Restart on the edge is what keeps the slave node locked to the far clock
    slave_restart_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        slave && ext_present && ext_rise && powered_r |=> cnt_r == 16'h0001)
        else $error("slave counter not restarted on external edge");
    lock_mode_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        sync_locked_o |-> mode_o[1])
        else $error("lock shown outside slave mode");
    sense_take_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !powered_r && freq_set_resistor_valid_i && freq_set_resistor_period_i >= sspm_pkg::PER_MIN
        |=> def_per_r == $past(freq_set_resistor_period_i))
        else $error("resistor measurement not taken");
    early_cmd_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !powered_r && freq_cmd_wr_i && !freq_set_resistor_valid_i |=> def_per_r == $past(def_per_r))
        else $error("frequency command taken before power up");
    min_period_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        def_per_r >= sspm_pkg::PER_MIN)
        else $error("default period below minimum");
    own_period_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !slave |-> period_o == def_per_r)
        else $error("own period not used outside slave mode");
endmodule : sspm_ctrl
`default_nettype wire

// ===== design/sspm_pkg.sv
// Constants and types for the switching sync mode control block
// Overview of operation
// - The switching configuration mode follows the value written with the phase-mode command.
// - In standalone mode (0x0000) the sync pin is released after power up and switching runs at the own frequency.
// - In master mode (0x0100) the sync pin is driven after power up with a 50 % duty pulse between low and high.
// - In master mode the sync pulse stays in phase with the own switching node.
// - In slave in phase mode (0x0120) the external clock on the sync pin sets the switching phase, in phase.
// - In slave 180 degree mode (0x0121) the switching node runs half a period away from the external clock.
// - In a slave mode an external clock present on the sync pin replaces the own switching frequency.
// - During power up the frequency-set resistor is sensed once and gives the default switching period.
// - A frequency command replaces the default period taken from the resistor measurement.
package sspm_pkg;
    localparam logic [15:0] PH_STANDALONE = 16'h0000;
    localparam logic [15:0] PH_MASTER = 16'h0100;
    localparam logic [15:0] PH_SLAVE_IN = 16'h0120;
    localparam logic [15:0] PH_SLAVE_180 = 16'h0121;
    localparam int PER_W = 16;
    localparam logic [15:0] PER_RESET = 16'h0064;
    localparam logic [15:0] PER_MIN = 16'h0004;
    // External clock counts as lost after this many cycles with no rising edge
    localparam logic [16:0] SYNC_LOST_CNT = 17'h10000;
    typedef enum logic [1:0] {
        SSPM_STANDALONE = 2'b00,
        SSPM_MASTER = 2'b01,
        SSPM_SLAVE_IN = 2'b10,
        SSPM_SLAVE_180 = 2'b11
    } sspm_mode_t;
endpackage : sspm_pkg

// ===== design/sspm_sync_detect.sv
// Sync pin input synchroniser, edge finder and period meter
`timescale 1ns/10ps
`default_nettype none
module sspm_sync_detect (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    output logic rise_o,
    output logic present_o,
    output logic [15:0] period_o
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    logic [16:0] cnt_r;

    // First stage read only by the second stage
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= pin_i;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end

    assign rise_o = sync_r & ~last_r;

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            cnt_r <= '0;
            present_o <= 1'b0;
            period_o <= '0;
        end else if (rise_o) begin
            cnt_r <= 17'h00001;
            // Needs two edges before the measured period is trusted
            present_o <= (cnt_r != '0) && (cnt_r < sspm_pkg::SYNC_LOST_CNT);
            period_o <= cnt_r[15:0];
        end else if (cnt_r != '0 && cnt_r < sspm_pkg::SYNC_LOST_CNT) begin
            cnt_r <= cnt_r + 17'h00001;
        end else if (cnt_r != '0) begin
            present_o <= 1'b0;
            cnt_r <= '0;
        end
    end
endmodule : sspm_sync_detect
`default_nettype wire

// ===== testbench/sspm_far_master.sv
// Far-side converter in master mode driving the shared sync pin
`timescale 1ns/10ps
`default_nettype none
module sspm_far_master (
    input wire logic en_i,
    output logic sync_o
);
    logic clk_r = 1'b0;
    // Runs only while enabled; once disabled the clock is forced low at its next toggle step
    initial begin
        #3;
        forever #80 clk_r = en_i ? ~clk_r : 1'b0;
    end
    assign sync_o = clk_r;
endmodule : sspm_far_master
`default_nettype wire

// ===== testbench/switching_sync_mode_control_test.sv
// Self-checking bench for the switching sync mode control
`timescale 1ns/10ps
`default_nettype none
module switching_sync_mode_control_test;
    logic core_clk_i = 1'b0, rst_i = 1'b1, mwr = 1'b0, fwr = 1'b0, rvld = 1'b0, smp = 1'b0, far_en = 1'b0;
    logic [15:0] mcmd = 16'h0000, fper = 16'h0000, rper = 16'h0000, f, r, per;
    logic pin_o, pin_oe, sense, sw, lock, far_pin;
    logic [1:0] mode;
    logic [21:0] q_e[$], q_m[$];
    logic [31:0] seed = 32'd31783;
    int n_fail = 0, n_compared = 0, i, n = 0;
    wire logic pin = pin_oe ? pin_o : far_pin;
    wire logic [21:0] obs = {sw, lock, sense, pin_oe, mode, per};
    always #5 core_clk_i = ~core_clk_i;
    sspm_ctrl DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .phase_mode_command_i(mcmd), .phase_mode_wr_i(mwr),
        .freq_cmd_period_i(fper), .freq_cmd_wr_i(fwr), .freq_set_resistor_period_i(rper),
        .freq_set_resistor_valid_i(rvld), .freq_set_sync_pin_i(pin), .freq_set_sync_pin_o(pin_o),
        .freq_set_sync_pin_oe_o(pin_oe), .sense_req_o(sense), .sw_node_o(sw), .mode_o(mode),
        .sync_locked_o(lock), .period_o(per));
    sspm_far_master far (.en_i(far_en), .sync_o(far_pin));
    function automatic logic [15:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[15:0];
    endfunction : rnd
    task automatic fail(input string s);
        n_fail++;
        $display("Error at %0t: %s", $time, s);
    endtask : fail
    task automatic tally_and_finish();
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // Write strobe k: 0 phase mode, 1 frequency, 2 resistor result
    task automatic wr(input int k, input logic [15:0] d);
        @(posedge core_clk_i);
        {mcmd, fper, rper} <= {d, d, d};
        {mwr, fwr, rvld} <= 3'(4 >> k);
        @(posedge core_clk_i);
        {mwr, fwr, rvld} <= 3'b000;
        @(posedge core_clk_i);
    endtask : wr
    task automatic note(input logic [21:0] e, input logic [21:0] m);
        q_e.push_back(e & m);
        q_m.push_back(m);
        @(posedge core_clk_i) smp <= 1'b1;
        @(posedge core_clk_i) smp <= 1'b0;
    endtask : note
    always @(posedge core_clk_i) begin
        if (smp) begin
            n_compared++;
            if ((obs & q_m[0]) !== q_e[0]) fail("output mismatch");
            void'(q_e.pop_front());
            void'(q_m.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge core_clk_i);
        n_fail++;
        tally_and_finish();
    end
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_i <= 1'b0;
        note(22'h080064, 22'h0fffff);
        r = rnd() % 16'd200 + 16'd8;
        wr(2, r);
        note({6'h00, r}, 22'h08ffff);
        wr(2, r + 16'd3);
        note({6'h00, r}, 22'h00ffff);
        // Even period only, so a 50 % duty is a whole number of cycles
        f = (rnd() % 16'd30 + 16'd10) * 16'd2;
        wr(1, f);
        note({6'h00, f}, 22'h00ffff);
        wr(0, 16'h0100);
        note({6'h05, f}, 22'h07ffff);
        for (i = 0; i < 2 * f; i++) begin
            @(negedge core_clk_i);
            n += int'(sw === 1'b1);
            if (pin_o !== sw) fail("sync pin off node");
        end
        n_compared++;
        if (n !== int'(f)) fail("master duty");
        wr(0, 16'h0042);
        note({6'h05, f}, 22'h07ffff);
        wr(0, 16'h0000);
        note({6'h00, f}, 22'h07ffff);
        far_en = 1'b1;
        // Sampled mid high half of the far clock, so either phase shows plainly
        for (i = 0; i < 2; i++) begin
            wr(0, i[0] ? 16'h0121 : 16'h0120);
            repeat (100) @(posedge core_clk_i);
            @(posedge pin);
            repeat (5) @(posedge core_clk_i);
            note({~i[0], 1'b1, 2'b00, 2'(2 + i), 16'h0000}, 22'h330000);
        end
        far_en = 1'b0;
        repeat (65600) @(posedge core_clk_i);
        note({6'h03, f}, 22'h13ffff);
        tally_and_finish();
    end
endmodule : switching_sync_mode_control_test
`default_nettype wire
